/* hw/radio_irq_map.svh */
`ifndef RADIO_IRQ_MAP_SVH
`define RADIO_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_L1_SYS_EN        10'h3C7
`define IDX_L1_PKT_EN        10'h3C8
`define IDX_L2_SYS_EN        10'h3C9
`define IDX_L2_PKT_EN        10'h3CA
`define IDX_SYS_SRC          10'h3CB
`define IDX_PKT_SRC          10'h3CC
`define IDX_BATT_CFG         10'h3E6
`define IDX_LEVELS           10'h3E7

// ----------------------------------------------------------------
// System source bits
// ----------------------------------------------------------------
`define SYS_POWERUP_BIT      1
`define SYS_WAKE_BIT         2
`define SYS_IDLE_BIT         3
`define SYS_POR_BIT          4
`define SYS_BATT_BIT         5

// ----------------------------------------------------------------
// Packet source bits
// ----------------------------------------------------------------
`define PKT_CCA_BIT          0
`define PKT_RX_DELIM_BIT     1
`define PKT_TX_DELIM_BIT     2
`define PKT_RX_FRAME_BIT     3
`define PKT_TX_FRAME_BIT     4

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define SYS_VALID_MASK       8'h3E
`define PKT_VALID_MASK       8'h1F
`define SYS_EN_RESET         8'h02
`define PKT_EN_RESET         8'h00
`define SRC_RESET            8'h00
`define BATT_CFG_RESET       5'h00

// ----------------------------------------------------------------
// Battery trip level in millivolts
// ----------------------------------------------------------------
`define BATT_BASE_MV         12'd1700
`define BATT_STEP_MV         12'd62

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

/* hw/radio_irq_pkg.sv */
package radio_irq_pkg;
    typedef logic [7:0]  reg8_t;
    typedef logic [11:0] millivolt_t;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;
endpackage : radio_irq_pkg

/* hw/event_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface event_if #(parameter int N = 8);
    logic [N-1:0] pulse;
    modport src (output pulse);
    modport dst (input pulse);
endinterface : event_if
`default_nettype wire

/* hw/event_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module event_edge_sync #(
    parameter int N = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] raw,
    event_if.src              ev
);
    import radio_irq_pkg::*;

    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;

    // ----------------------------------------------------------------
    // Two flops per pin, then a rising edge makes one pulse
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta[i]     <= 1'b0;
                sync[i]     <= 1'b0;
                prev[i]     <= 1'b0;
                ev.pulse[i] <= 1'b0;
            end else begin
                meta[i]     <= raw[i];
                sync[i]     <= meta[i];
                prev[i]     <= sync[i];
                ev.pulse[i] <= sync[i] & ~prev[i];
            end
        end
    end
endmodule : event_edge_sync
`default_nettype wire

/* hw/radio_event_interrupt_mask.sv */
// How it works
// - Controller idle sets system bit 3; power-on event reported at bit 4.
// - Chip ready sets system bit 1; its line enables reset to 1, others 0.
// - Wake timer expiry sets system bit 2; supply-low reported at bit 5.
// - Stored frame sets packet bit 3; sent 4, delimiter sent 2, seen 1.
// - Valid channel check result sets packet bit 0.
// - Supply-low fires below 1700 mV plus 62 mV times five-bit setting.
`include "radio_irq_map.svh"
`timescale 1ns/10ps
`default_nettype none
module radio_event_interrupt_mask #(
    parameter int ADDR_W = 12
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     powerup_done,
    input  wire logic                     wake_timeout,
    input  wire logic                     controller_idle,
    input  wire logic                     cca_valid,
    input  wire logic                     rx_delim_seen,
    input  wire logic                     tx_delim_sent,
    input  wire logic                     rx_frame_stored,
    input  wire logic                     tx_frame_sent,
    input  wire radio_irq_pkg::millivolt_t supply_mv,
    output logic                          irq_line1,
    output logic                          irq_line2
);
    import radio_irq_pkg::*;

    // ----------------------------------------------------------------
    // Event pins
    // ----------------------------------------------------------------
    localparam int NEV = 8;

    event_if #(.N(NEV)) ev ();

    event_edge_sync #(.N(NEV)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({tx_frame_sent, rx_frame_stored, tx_delim_sent, rx_delim_seen,
                   cca_valid, controller_idle, wake_timeout, powerup_done}),
        .ev      (ev.src)
    );

    logic ev_powerup;
    logic ev_wake;
    logic ev_idle;
    logic ev_cca;
    logic ev_rx_delim;
    logic ev_tx_delim;
    logic ev_rx_frame;
    logic ev_tx_frame;

    assign ev_powerup  = ev.pulse[0];
    assign ev_wake     = ev.pulse[1];
    assign ev_idle     = ev.pulse[2];
    assign ev_cca      = ev.pulse[3];
    assign ev_rx_delim = ev.pulse[4];
    assign ev_tx_delim = ev.pulse[5];
    assign ev_rx_frame = ev.pulse[6];
    assign ev_tx_frame = ev.pulse[7];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg8_t      l1_sys_en;
    reg8_t      l1_pkt_en;
    reg8_t      l2_sys_en;
    reg8_t      l2_pkt_en;
    reg8_t      sys_src;
    reg8_t      pkt_src;
    logic [4:0] batt_cfg;
    logic       por_pending;
    logic       batt_low;
    logic       batt_low_prev;
    millivolt_t trip_mv;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    wr_state_e         wr_state;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_do;
    logic [9:0]        wr_idx;
    logic              wr_hit;

    assign wr_do  = (wr_state == WR_IDLE) && aw_got && w_got;
    assign wr_idx = aw_addr[11:2];

    always_comb begin
        case (wr_idx)
            `IDX_L1_SYS_EN, `IDX_L1_PKT_EN, `IDX_L2_SYS_EN, `IDX_L2_PKT_EN,
            `IDX_SYS_SRC, `IDX_PKT_SRC, `IDX_BATT_CFG, `IDX_LEVELS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state      <= WR_IDLE;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    // Address and data may come in either order
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_got        <= 1'b1;
                        aw_addr       <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_got        <= 1'b1;
                        w_data       <= s_axi_wdata;
                        w_strb       <= s_axi_wstrb;
                        s_axi_wready <= 1'b0;
                    end
                    if (wr_do) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                        wr_state     <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        aw_got        <= 1'b0;
                        w_got         <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        wr_state      <= WR_IDLE;
                    end
                end
                default: wr_state <= WR_IDLE;
            endcase
        end
    end

    logic  wr_lane0;
    reg8_t wbyte;

    assign wr_lane0 = wr_do && w_strb[0];
    assign wbyte    = w_data[7:0];

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    rd_state_e  rd_state;
    logic       rd_take;
    logic [9:0] rd_idx;
    reg8_t      rd_val;
    logic       rd_hit;

    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_idx  = s_axi_araddr[11:2];

    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            `IDX_L1_SYS_EN: rd_val = l1_sys_en;
            `IDX_L1_PKT_EN: rd_val = l1_pkt_en;
            `IDX_L2_SYS_EN: rd_val = l2_sys_en;
            `IDX_L2_PKT_EN: rd_val = l2_pkt_en;
            `IDX_SYS_SRC:   rd_val = sys_src;
            `IDX_PKT_SRC:   rd_val = pkt_src;
            `IDX_BATT_CFG:  rd_val = {3'b000, batt_cfg};
            `IDX_LEVELS:    rd_val = {5'b00000, batt_low, irq_line2, irq_line1};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state      <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (rd_take) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= {24'h000000, rd_val};
                        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
                        rd_state      <= RD_RESP;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state      <= RD_IDLE;
                    end
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Enable registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            l1_sys_en <= `SYS_EN_RESET;
            l2_sys_en <= `SYS_EN_RESET;
            l1_pkt_en <= `PKT_EN_RESET;
            l2_pkt_en <= `PKT_EN_RESET;
            batt_cfg  <= `BATT_CFG_RESET;
        end else if (wr_lane0) begin
            // Reserved bits never store, so they read back as zero
            case (wr_idx)
                `IDX_L1_SYS_EN: l1_sys_en <= wbyte & `SYS_VALID_MASK;
                `IDX_L1_PKT_EN: l1_pkt_en <= wbyte & `PKT_VALID_MASK;
                `IDX_L2_SYS_EN: l2_sys_en <= wbyte & `SYS_VALID_MASK;
                `IDX_L2_PKT_EN: l2_pkt_en <= wbyte & `PKT_VALID_MASK;
                `IDX_BATT_CFG:  batt_cfg  <= wbyte[4:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Supply monitor
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_mv       <= `BATT_BASE_MV;
            batt_low      <= 1'b0;
            batt_low_prev <= 1'b0;
        end else begin
            // Registered to keep the multiply off the compare path
            trip_mv       <= `BATT_BASE_MV + 12'(`BATT_STEP_MV * 12'(batt_cfg));
            batt_low      <= supply_mv < trip_mv;
            batt_low_prev <= batt_low;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_pending <= 1'b1;
        end else begin
            por_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Source flags, set wins over read or write clear
    // ----------------------------------------------------------------
    reg8_t sys_set;
    reg8_t pkt_set;
    reg8_t sys_clr;
    reg8_t pkt_clr;

    always_comb begin
        sys_set = 8'h00;
        pkt_set = 8'h00;
        sys_set[`SYS_POWERUP_BIT]  = ev_powerup;
        sys_set[`SYS_WAKE_BIT]     = ev_wake;
        sys_set[`SYS_IDLE_BIT]     = ev_idle;
        sys_set[`SYS_POR_BIT]      = por_pending;
        sys_set[`SYS_BATT_BIT]     = batt_low && !batt_low_prev;
        pkt_set[`PKT_CCA_BIT]      = ev_cca;
        pkt_set[`PKT_RX_DELIM_BIT] = ev_rx_delim;
        pkt_set[`PKT_TX_DELIM_BIT] = ev_tx_delim;
        pkt_set[`PKT_RX_FRAME_BIT] = ev_rx_frame;
        pkt_set[`PKT_TX_FRAME_BIT] = ev_tx_frame;
    end

    always_comb begin
        sys_clr = 8'h00;
        pkt_clr = 8'h00;
        if (rd_take && rd_idx == `IDX_SYS_SRC) begin
            sys_clr = 8'hFF;
        end
        if (rd_take && rd_idx == `IDX_PKT_SRC) begin
            pkt_clr = 8'hFF;
        end
        if (wr_lane0 && wr_idx == `IDX_SYS_SRC) begin
            sys_clr = sys_clr | wbyte;
        end
        if (wr_lane0 && wr_idx == `IDX_PKT_SRC) begin
            pkt_clr = pkt_clr | wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_src <= `SRC_RESET;
            pkt_src <= `SRC_RESET;
        end else begin
            sys_src <= ((sys_src & ~sys_clr) | sys_set) & `SYS_VALID_MASK;
            pkt_src <= ((pkt_src & ~pkt_clr) | pkt_set) & `PKT_VALID_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt lines
    // ----------------------------------------------------------------
    logic next_irq_line1;
    logic next_irq_line2;

    assign next_irq_line1 = |(sys_src & l1_sys_en) || |(pkt_src & l1_pkt_en);
    assign next_irq_line2 = |(sys_src & l2_sys_en) || |(pkt_src & l2_pkt_en);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_line1 <= 1'b0;
            irq_line2 <= 1'b0;
        end else begin
            irq_line1 <= next_irq_line1;
            irq_line2 <= next_irq_line2;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_src_read;
        rd_take && rd_idx == `IDX_SYS_SRC && sys_set == 8'h00;
    endsequence

    // Data leaves with the clear, so rvalid stands in the same cycle as the empty source
    sequence s_src_empty;
        sys_src == 8'h00 && s_axi_rvalid;
    endsequence

    a_idle_sets_flag: assert property (ev_idle |=> sys_src[`SYS_IDLE_BIT])
        else $error("controller idle event did not set its flag");

    a_enable_reset_val: assert property ($past(!aresetn) |-> l1_sys_en == 8'h02 && l2_sys_en == 8'h02
                                          && l1_pkt_en == 8'h00 && l2_pkt_en == 8'h00)
        else $error("enable registers left reset with wrong value");

    a_ready_sets_flag: assert property (ev_powerup |=> sys_src[`SYS_POWERUP_BIT])
        else $error("ready event did not set its flag");

    a_wake_sets_flag: assert property (ev_wake |=> sys_src[`SYS_WAKE_BIT])
        else $error("wake event did not set its flag");

    a_frame_rx_flag: assert property (ev_rx_frame |=> pkt_src[`PKT_RX_FRAME_BIT] && pkt_src[7:5] == 3'b000)
        else $error("received frame did not set its flag");

    a_cca_sets_flag: assert property (ev_cca |=> pkt_src[`PKT_CCA_BIT])
        else $error("channel check event did not set its flag");

    a_batt_trip_level: assert property (
        trip_mv == 12'(`BATT_BASE_MV + `BATT_STEP_MV * 12'($past(batt_cfg)))
        |=> batt_low == ($past(supply_mv) < $past(trip_mv)))
        else $error("supply-low compare wrong");

    a_batt_sets_flag: assert property ($rose(batt_low) |=> sys_src[`SYS_BATT_BIT])
        else $error("supply-low did not set its flag");

    a_line1_follows: assert property (1'b1 |=> irq_line1 == $past(|(sys_src & l1_sys_en) || |(pkt_src & l1_pkt_en)))
        else $error("line 1 does not follow enabled flags");

    a_line2_enabled: assert property ((|(pkt_src & l2_pkt_en)) [*2] |-> irq_line2)
        else $error("line 2 idle while enabled packet flag held");

    a_read_clears: assert property (s_src_read |=> s_src_empty)
        else $error("read of system source did not clear it");

endmodule : radio_event_interrupt_mask
`default_nettype wire

/* dv/irq_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       irq_line1,
    input  wire logic       irq_line2,
    output logic [7:0]      svc1,
    output logic [7:0]      svc2
);
    logic p1;
    logic p2;
    // Level lines: a held request is serviced once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {p1, p2, svc1, svc2} <= 18'h00000;
        end else begin
            p1 <= irq_line1;
            p2 <= irq_line2;
            if (irq_line1 && !p1) svc1 <= svc1 + 8'h01;
            if (irq_line2 && !p2) svc2 <= svc2 + 8'h01;
        end
    end
endmodule : irq_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "radio_irq_map.svh"
module tb_top;
    import radio_irq_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq_line1, irq_line2, e1, e2;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  ev = 8'h00, d, m, svc1, svc2, n1 = 8'h00, n2 = 8'h00;
    logic [7:0]  en [4];
    millivolt_t  supply_mv = 12'hFA0;
    int          seed = 49, failures = 0, num_checks = 0, g;
    int          trips [3] = '{0, 31, 0};

    always #10 aclk = ~aclk;

    radio_event_interrupt_mask dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .powerup_done(ev[0]), .wake_timeout(ev[1]), .controller_idle(ev[2]), .cca_valid(ev[3]),
        .rx_delim_seen(ev[4]), .tx_delim_sent(ev[5]), .rx_frame_stored(ev[6]),
        .tx_frame_sent(ev[7]), .supply_mv(supply_mv), .irq_line1(irq_line1), .irq_line2(irq_line2)
    );

    irq_host_model host (
        .aclk(aclk), .aresetn(aresetn), .irq_line1(irq_line1), .irq_line2(irq_line2),
        .svc1(svc1), .svc2(svc2)
    );

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk

    // Channels released one by one; answer awaited, never counted on
    task automatic axi_wr(input logic [9:0] idx, input logic [7:0] v, output logic [1:0] rs);
        int  n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, v};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] idx, output logic [7:0] v, output logic [1:0] rs);
        int  n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        {arvalid, rready} <= 2'b11;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                {rs, v} = {rresp, rdata[7:0]};
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_rd

    function automatic logic [7:0] exp_bit(input int k);
        return (k < 3) ? 8'h01 << (k + 1) : 8'h01 << (k - 3);
    endfunction : exp_bit

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        cyc(20);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            axi_rd(10'(`IDX_L1_SYS_EN + i), d, r);
            chk(d, (i % 2) ? `PKT_EN_RESET : `SYS_EN_RESET);
        end
        axi_rd(`IDX_SYS_SRC, d, r);
        chk(d, 8'h10);
        axi_rd(`IDX_SYS_SRC, d, r);
        chk(d, 8'h00);
        axi_rd(10'h000, d, r);
        chk({r, d}, {`RESP_SLVERR, 8'h00});
        axi_wr(10'h000, 8'h55, r);
        chk(r, `RESP_SLVERR);
        $display("reset and map test done");
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
                en[i] = 8'($random(seed)) & ((i % 2) ? `PKT_VALID_MASK : `SYS_VALID_MASK);
                axi_wr(10'(`IDX_L1_SYS_EN + i), en[i], r);
                axi_rd(10'(`IDX_L1_SYS_EN + i), d, r);
                chk(d, en[i]);
            end
            // Pulse held a few cycles so the pin synchroniser cannot miss it
            ev[k] <= 1'b1;
            cyc(3);
            ev[k] <= 1'b0;
            cyc(6);
            m = exp_bit(k);
            g = (k > 2);
            e1 = |(m & en[g]);
            e2 = |(m & en[g + 2]);
            chk({irq_line1, irq_line2}, {e1, e2});
            axi_rd(g ? `IDX_PKT_SRC : `IDX_SYS_SRC, d, r);
            chk(d, m);
            cyc(2);
            chk({irq_line1, irq_line2}, 2'b00);
            n1 += 8'(e1);
            n2 += 8'(e2);
        end
        chk({svc1, svc2}, {n1, n2});
        $display("event test done");
        trips[2] = $random(seed) & 31;
        axi_wr(`IDX_L1_SYS_EN, 8'h00, r);
        axi_wr(`IDX_L2_SYS_EN, 8'h20, r);
        foreach (trips[i]) begin
            axi_wr(`IDX_BATT_CFG, 8'(trips[i]), r);
            supply_mv <= 12'(1700 + 62 * trips[i]);
            cyc(6);
            axi_rd(`IDX_SYS_SRC, d, r);
            chk(d, 8'h00);
            supply_mv <= 12'(1699 + 62 * trips[i]);
            cyc(6);
            chk({irq_line1, irq_line2}, 2'b01);
            axi_rd(`IDX_SYS_SRC, d, r);
            chk(d, 8'h20);
            supply_mv <= 12'hFA0;
            cyc(4);
        end
        $display("supply test done");
        close_out;
    end

    initial begin
        cyc(6000);
        failures++;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
